// [ccp_pwm_defs.svh]
/*
  Register offsets, field positions, reset values and prescaler
  terminal counts for the pwm unit.
  Assumes an 8-bit register port and one core clock.
*/
`ifndef CCP_PWM_DEFS_SVH
`define CCP_PWM_DEFS_SVH
`define ADR_PORT 8'h06
`define ADR_PIN_DATA 8'h07
`define ADR_INT_CTL 8'h0B
`define ADR_FLAGS 8'h0C
`define ADR_TMR 8'h11
`define ADR_TCTL 8'h12
`define ADR_DUTY_LO 8'h15
`define ADR_DUTY_SH 8'h16
`define ADR_UCTL 8'h17
`define ADR_DIR 8'h87
`define ADR_ENABLES 8'h8C
`define ADR_PERIOD 8'h92
`define BIT_PIN 2
`define BIT_PORT 3
`define BIT_RUN 2
`define BIT_CAP_FLAG 2
`define BIT_TMR_FLAG 1
`define MASK_FLAGS 8'h47
`define MASK_TCTL 8'h7F
`define MASK_UCTL 8'h3F
`define MASK_PIN 8'h05
`define RST_PERIOD 8'hFF
`define RST_DIR 8'h05
`define PS_LAST1 6'h03
`define PS_LAST4 6'h0F
`define PS_LAST16 6'h3F
`endif

// [ccp_pwm_pkg.sv]
/*
  Types for the pwm unit: unit modes and the packed state record.
  Assumes the defs header for all numeric values.
*/
package ccp_pwm_pkg;
  // unit operating mode decoded from mode_select
  typedef enum logic [1:0] {
    MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_PWM
  } mode_t;
  // whole register state of the unit
  typedef struct packed {
    logic [7:0] port;
    logic [7:0] pin_latch;
    logic [7:0] intc;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] tmr;
    logic [7:0] tctl;
    logic [7:0] duty_lo;
    logic [7:0] duty_sh;
    logic [7:0] uctl;
    logic [7:0] dir;
    logic [7:0] period;
    logic [1:0] frac;
    logic [5:0] fine;
    logic [3:0] post;
    logic sync1;
    logic sync2;
    logic sync3;
    logic out_latch;
    logic pin_out;
    logic pin_oe;
    logic [7:0] rdata;
  } state_t;
endpackage

// [ccp_pwm_with_pin_mux.sv]
/*
  Capture/compare/pwm unit in pwm mode with shared pin multiplexing,
  timer time base and register file on a plain strobe port.
  Assumes one core clock, a synchronous reset and a testbench that
  resolves the shared pin from pin_o and pin_oe_o.
*/
// Local design decision: the strobed register port.
// Function
// - pwm on shared pin, driven when direction cleared
// - zero control write forces output latch low
// - period match clears timer next increment
// - period match sets pin unless duty zero
// - period match loads duty into shadow
// - postscaler never touches pwm period
// - duty is low byte plus control bits 5:4
// - high time is duty times clock times prescale
// - new duty waits for period end
// - shadow read only in pwm mode
// - shadow plus 2-bit latch double buffer
// - pin cleared when shadow equals extended timer
// - duty beyond period keeps pin high
// - prescale ratios one, four, sixteen
// - mode 0000 gives plain port pin
// - mode 11xx drives pwm, pin bit reads level
// - mode 10xx drives compare output
// - enabled unit: port input reads zero
// - mode 01xx to 11xx: port writes only store latch
`timescale 1ns/1ps
`include "ccp_pwm_defs.svh"
module ccp_pwm_with_pin_mux (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic pin_i,
  input wire logic cmp_event_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic [7:0] rdata_o
);
  // reset image: period all ones, direction bits as inputs
  localparam ccp_pwm_pkg::state_t RESET_STATE = '{
    period: `RST_PERIOD, dir: `RST_DIR, default: '0};

  ccp_pwm_pkg::state_t s; // registered state
  ccp_pwm_pkg::state_t next_s; // next state
  ccp_pwm_pkg::mode_t mode; // current unit mode
  logic enabled; // mode_select not 0000
  logic tick; // timer increment cycle
  logic match; // period match on this increment
  logic [5:0] last; // prescaler terminal count
  logic [1:0] ext; // two low bits below timer
  logic [1:0] next_ext; // extension bits one clock ahead
  logic [9:0] duty10; // software duty value
  logic [9:0] shadow10; // buffered duty value
  logic cap_set; // capture edge seen
  logic tmr_set; // postscaler rollover

  // mode decode, shared by pin mux, writes and checks
  function automatic ccp_pwm_pkg::mode_t mode_of(input logic [7:0] c);
    case (c[3:2])
      2'b01: mode_of = ccp_pwm_pkg::MODE_CAPTURE;
      2'b10: mode_of = ccp_pwm_pkg::MODE_COMPARE;
      2'b11: mode_of = ccp_pwm_pkg::MODE_PWM;
      default: mode_of = ccp_pwm_pkg::MODE_OFF;
    endcase
  endfunction

  // extension bits below the timer for a prescale code; used by the
  // next-count duty compare only; the present-count ext comes from the prescale case
  function automatic logic [1:0] ext_of(input logic [1:0] ps,
                                         input logic [5:0] f);
    case (ps)
      2'b00: ext_of = f[1:0];
      2'b01: ext_of = f[3:2];
      default: ext_of = f[5:4];
    endcase
  endfunction

  // all next-state logic
  always_comb begin
    next_s = s;
    mode = mode_of(s.uctl);
    enabled = (s.uctl[3:0] != 4'h0);
    // pin input synchroniser, first stage read only by second
    next_s.sync1 = pin_i;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    // prescale select and extension bits
    case (s.tctl[1:0])
      2'b00: begin
        last = `PS_LAST1;
        ext = s.fine[1:0];
      end
      2'b01: begin
        last = `PS_LAST4;
        ext = s.fine[3:2];
      end
      default: begin
        last = `PS_LAST16;
        ext = s.fine[5:4];
      end
    endcase
    tick = s.tctl[`BIT_RUN] && (s.fine == last);
    match = tick && (s.tmr == s.period);
    duty10 = {s.duty_lo, s.uctl[5:4]};
    shadow10 = {s.duty_sh, s.frac};
    cap_set = 1'b0;
    tmr_set = 1'b0;
    // fine counter: q clock or prescaler bits
    if (s.tctl[`BIT_RUN]) begin
      next_s.fine = tick ? 6'h00 : s.fine + 6'h01;
    end
    // timer count and period reload
    if (tick) begin
      next_s.tmr = match ? 8'h00 : s.tmr + 8'h01;
    end
    // the count the timer holds after this edge; a clear taken on it
    // lands when the count reaches the duty, not one clock later
    next_ext = ext_of(s.tctl[1:0], next_s.fine);
    // pwm output latch; reload beats the clear compare
    if (mode == ccp_pwm_pkg::MODE_PWM) begin
      if (match) begin
        next_s.duty_sh = s.duty_lo;
        next_s.frac = s.uctl[5:4];
        next_s.out_latch = (duty10 != 10'h000);
      end else if ({s.tmr, ext} == shadow10 ||
                   {next_s.tmr, next_ext} == shadow10) begin
        // present-count term catches a count that a timer write
        // jumped onto the duty; never reached when duty exceeds
        // the period, so the pin then stays high
        next_s.out_latch = 1'b0;
      end
    end
    // compare event drives the same output latch
    if (mode == ccp_pwm_pkg::MODE_COMPARE && cmp_event_i) begin
      if (s.uctl[1:0] == 2'b00) begin
        next_s.out_latch = 1'b1;
      end else if (s.uctl[1:0] == 2'b01) begin
        next_s.out_latch = 1'b0;
      end
    end
    // capture edge on the pin level, falling or rising
    if (mode == ccp_pwm_pkg::MODE_CAPTURE) begin
      if (s.uctl[1:0] == 2'b00) begin
        cap_set = s.sync3 && !s.sync2;
      end else begin
        cap_set = !s.sync3 && s.sync2;
      end
    end
    // postscaler counts periods, timer flag only
    if (match) begin
      if (s.post == s.tctl[6:3]) begin
        next_s.post = 4'h0;
        tmr_set = 1'b1;
      end else begin
        next_s.post = s.post + 4'h1;
      end
    end
    // software writes win over hardware counting
    if (we_i) begin
      if (addr_i == `ADR_PORT) begin
        next_s.port = wdata_i;
      end else if (addr_i == `ADR_PIN_DATA) begin
        next_s.pin_latch = wdata_i & `MASK_PIN;
      end else if (addr_i == `ADR_INT_CTL) begin
        next_s.intc = wdata_i;
      end else if (addr_i == `ADR_FLAGS) begin
        // a same-cycle hardware set below still wins
        next_s.flags = wdata_i & `MASK_FLAGS;
      end else if (addr_i == `ADR_ENABLES) begin
        next_s.enables = wdata_i & `MASK_FLAGS;
      end else if (addr_i == `ADR_TMR) begin
        // restart the prescaler with the new count
        next_s.tmr = wdata_i;
        next_s.fine = 6'h00;
      end else if (addr_i == `ADR_TCTL) begin
        next_s.tctl = wdata_i & `MASK_TCTL;
      end else if (addr_i == `ADR_DUTY_LO) begin
        next_s.duty_lo = wdata_i;
      end else if (addr_i == `ADR_DUTY_SH) begin
        if (mode != ccp_pwm_pkg::MODE_PWM) begin
          next_s.duty_sh = wdata_i;
        end
      end else if (addr_i == `ADR_UCTL) begin
        next_s.uctl = wdata_i & `MASK_UCTL;
        if (wdata_i == 8'h00) begin
          next_s.out_latch = 1'b0;
        end
      end else if (addr_i == `ADR_DIR) begin
        // only the direction bits exist; the rest read zero
        next_s.dir = wdata_i & `MASK_PIN;
      end else if (addr_i == `ADR_PERIOD) begin
        // a period below the running count lets the timer wrap
        // through 0xFF before the next match
        next_s.period = wdata_i;
      end
    end
    // hardware set beats a software clear in the same cycle
    if (cap_set) begin
      next_s.flags[`BIT_CAP_FLAG] = 1'b1;
    end
    if (tmr_set) begin
      next_s.flags[`BIT_TMR_FLAG] = 1'b1;
    end
    // shared pin mux; drive only with direction cleared
    next_s.pin_oe = !next_s.dir[`BIT_PIN];
    case (mode_of(next_s.uctl))
      ccp_pwm_pkg::MODE_OFF: begin
        next_s.pin_out = next_s.port[`BIT_PORT];
      end
      ccp_pwm_pkg::MODE_CAPTURE: begin
        next_s.pin_out = next_s.pin_latch[`BIT_PIN];
      end
      default: begin
        next_s.pin_out = next_s.out_latch;
      end
    endcase
    // read data, valid the cycle after the strobe only
    next_s.rdata = 8'h00;
    if (re_i) begin
      if (addr_i == `ADR_PORT) begin
        next_s.rdata = s.port;
        if (!enabled) begin
          next_s.rdata[`BIT_PORT] = s.sync2;
        end else if (s.dir[`BIT_PIN]) begin
          next_s.rdata[`BIT_PORT] = 1'b0;
        end else begin
          next_s.rdata[`BIT_PORT] = s.port[`BIT_PORT];
        end
      end else if (addr_i == `ADR_PIN_DATA) begin
        // pin data bit shows the pin level
        next_s.rdata = s.pin_latch;
        next_s.rdata[`BIT_PIN] = s.sync2;
      end else if (addr_i == `ADR_INT_CTL) begin
        next_s.rdata = s.intc;
      end else if (addr_i == `ADR_FLAGS) begin
        next_s.rdata = s.flags;
      end else if (addr_i == `ADR_ENABLES) begin
        next_s.rdata = s.enables;
      end else if (addr_i == `ADR_TMR) begin
        next_s.rdata = s.tmr;
      end else if (addr_i == `ADR_TCTL) begin
        next_s.rdata = s.tctl;
      end else if (addr_i == `ADR_DUTY_LO) begin
        next_s.rdata = s.duty_lo;
      end else if (addr_i == `ADR_DUTY_SH) begin
        next_s.rdata = s.duty_sh;
      end else if (addr_i == `ADR_UCTL) begin
        next_s.rdata = s.uctl;
      end else if (addr_i == `ADR_DIR) begin
        next_s.rdata = s.dir;
      end else if (addr_i == `ADR_PERIOD) begin
        next_s.rdata = s.period;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign pin_o = s.pin_out;
  assign pin_oe_o = s.pin_oe;
  assign rdata_o = s.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // pin enable follows the direction bit after a write
  pin_enable_a: assert property (
    we_i && addr_i == `ADR_DIR |=> pin_oe_o == !$past(wdata_i[2]))
    else $error("pin enable does not follow direction");

  // zero control write kills the output latch
  zero_control_a: assert property (
    we_i && addr_i == `ADR_UCTL && wdata_i == 8'h00
    |=> !s.out_latch && pin_o == s.port[`BIT_PORT])
    else $error("zero control write left output high");

  // period match restarts the timer
  period_clear_a: assert property (
    match && !we_i |=> s.tmr == 8'h00)
    else $error("timer not cleared on period match");

  // pwm set at period start unless duty zero
  pwm_set_a: assert property (
    match && mode == ccp_pwm_pkg::MODE_PWM && !we_i
    |=> s.out_latch == ($past(duty10) != 10'h000))
    else $error("pwm latch wrong at period start");

  // shadow takes the software duty at match
  shadow_load_a: assert property (
    match && mode == ccp_pwm_pkg::MODE_PWM
    |=> {s.duty_sh, s.frac} == $past(duty10))
    else $error("shadow not loaded at period match");

  // shadow holds against writes in pwm mode
  shadow_hold_a: assert property (
    mode == ccp_pwm_pkg::MODE_PWM && !match
    |=> s.duty_sh == $past(s.duty_sh))
    else $error("shadow changed mid period");

  // output clears where extended timer meets shadow
  duty_clear_a: assert property (
    mode == ccp_pwm_pkg::MODE_PWM && !match && !we_i
    && {s.tmr, ext} == shadow10 ##1 s.pin_oe
    |-> !pin_o)
    else $error("pwm pin not cleared at duty match");

  // duty beyond period keeps the output high
  over_duty_a: assert property (
    mode == ccp_pwm_pkg::MODE_PWM && s.out_latch && !we_i
    && shadow10 > {s.period, 2'b11} |=> s.out_latch)
    else $error("pwm cleared with duty beyond period");

  // enabled unit reads zero on an input port bit
  port_read_a: assert property (
    re_i && addr_i == `ADR_PORT && enabled && s.dir[2]
    |=> rdata_o[3] == 1'b0)
    else $error("port bit not zero while unit enabled");

  // timer moves only on a prescaler terminal count
  timer_step_a: assert property (
    s.tctl[`BIT_RUN] && !we_i && s.fine != last
    |=> s.tmr == $past(s.tmr))
    else $error("timer stepped between prescaler ends");

  // fraction latch holds through the period
  frac_hold_a: assert property (
    mode == ccp_pwm_pkg::MODE_PWM && !match
    |=> s.frac == $past(s.frac))
    else $error("duty fraction changed mid period");

  // plain port pin while the unit is off
  off_pin_a: assert property (
    mode == ccp_pwm_pkg::MODE_OFF && !we_i
    |=> pin_o == s.port[`BIT_PORT])
    else $error("off unit pin not from port latch");

  // pwm mode puts the output latch on the pin
  pwm_pin_a: assert property (
    mode == ccp_pwm_pkg::MODE_PWM && !we_i
    |=> pin_o == s.out_latch)
    else $error("pwm pin not from output latch");

  // compare event with the set code raises the latch
  compare_set_a: assert property (
    mode == ccp_pwm_pkg::MODE_COMPARE && cmp_event_i && !we_i
    && s.uctl[1:0] == 2'b00 |=> s.out_latch)
    else $error("compare event did not set output");

  // port writes stay in the latch while the mode is not off (bits 3:2 nonzero)
  port_write_a: assert property (
    we_i && addr_i == `ADR_PORT && mode != ccp_pwm_pkg::MODE_OFF
    |=> pin_o == (mode == ccp_pwm_pkg::MODE_CAPTURE ?
      s.pin_latch[`BIT_PIN] : s.out_latch))
    else $error("port write reached the pin");

  pwm_period_c: cover property (
    match && mode == ccp_pwm_pkg::MODE_PWM && duty10 != 10'h000);
  pwm_zero_c: cover property (
    match && mode == ccp_pwm_pkg::MODE_PWM && duty10 == 10'h000);
  compare_hit_c: cover property (
    mode == ccp_pwm_pkg::MODE_COMPARE && cmp_event_i);
  capture_hit_c: cover property (cap_set);
  over_duty_c: cover property (
    mode == ccp_pwm_pkg::MODE_PWM && shadow10 > {s.period, 2'b11});
endmodule

// [pwm_load_model.sv]
/*
  Behavioural load on the shared pin; works out the wire level.
  Assumes the unit's pin_o and pin_oe_o; no other driver exists.
*/
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic level_o
);
  logic last_drv = 1'b0; // level the unit last put on the wire
  // remember the driven level while the unit holds the pin
  always @(posedge clk_i) begin
    if (pin_oe_i) begin
      last_drv <= pin_i;
    end
  end
  // released wire shows the inverse, so a stale level never passes
  assign level_o = pin_oe_i ? pin_i : ~last_drv;
endmodule

// [ccp_pwm_with_pin_mux_tb.sv]
/*
  Self-checking bench: register port tasks, pwm high time per
  prescale code, pin multiplexing per mode.
  Assumes the load model resolves the shared pin into pin_i.
*/
`timescale 1ns/1ps
`include "ccp_pwm_defs.svh"
module ccp_pwm_with_pin_mux_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic cmp_event_i = 1'b0;
  logic pin_o;
  logic pin_oe_o;
  logic level; // resolved wire
  logic [7:0] rdata_o;
  logic [7:0] rv;
  int failures = 0;
  int n_tests = 0;
  int cnt;
  // reset table, last entry an unmapped hole
  logic [7:0] ra [8] = '{`ADR_PERIOD, `ADR_TMR, `ADR_TCTL, `ADR_UCTL,
    `ADR_FLAGS, `ADR_ENABLES, `ADR_DIR, 8'h40};
  logic [7:0] rx [8] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    `RST_DIR, 8'h00};
  // timer control codes; the last sets postscale bits
  logic [7:0] tc [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h7C};
  int pv [5] = '{1, 4, 16, 16, 1};

  ccp_pwm_with_pin_mux i_ccp_pwm_with_pin_mux (.clk_i(clk_i),
    .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .pin_i(level), .cmp_event_i(cmp_event_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .rdata_o(rdata_o));
  pwm_load_model i_pwm_load_model (.clk_i(clk_i), .pin_i(pin_o),
    .pin_oe_i(pin_oe_o), .level_o(level));

  // 200 MHz core clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // counts high cycles of the wire over a fixed window
  task automatic meas(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (level === 1'b1) c++;
    end
  endtask

  task automatic pulse();
    @(posedge clk_i);
    cmp_event_i <= 1'b1;
    @(posedge clk_i);
    cmp_event_i <= 1'b0;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: far beyond the longest sequence
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv);
      chk_reg("reset value", rx[i], rv);
    end
    $display("test reset done");
    // set-up: period 3, duty 9 (byte 02, fraction 01)
    wr(`ADR_PERIOD, 8'h03);
    wr(`ADR_DUTY_LO, 8'h02);
    wr(`ADR_UCTL, 8'h10);
    wr(`ADR_DIR, 8'h00);
    wr(`ADR_TCTL, 8'h04);
    wr(`ADR_UCTL, 8'h1C);
    // period is 16 ticks of prescale; high is 9 of them; the extra 64
    // lets a prescaler left above the new terminal count wrap round
    for (int i = 0; i < 5; i++) begin
      wr(`ADR_TCTL, tc[i]);
      meas(32 * pv[i] + 64, cnt);
      meas(16 * pv[i], cnt);
      chk_cnt("high time", 9 * pv[i], cnt);
    end
    $display("test prescale done");
    wr(`ADR_DUTY_SH, 8'hAA);
    rd(`ADR_DUTY_SH, rv);
    chk_reg("shadow", 8'h02, rv);
    // zero duty while port latch bit is high
    wr(`ADR_DUTY_LO, 8'h00);
    wr(`ADR_UCTL, 8'h0C);
    wr(`ADR_PORT, 8'h08);
    meas(32, cnt);
    meas(16, cnt);
    chk_cnt("zero duty", 0, cnt);
    rd(`ADR_PORT, rv);
    chk_reg("port out read", 8'h08, rv & 8'h08);
    wr(`ADR_DIR, 8'h04);
    rd(`ADR_PORT, rv);
    chk_reg("port in read", 8'h00, rv & 8'h08);
    chk_reg("pin enable", 8'h00, {7'h0, pin_oe_o});
    wr(`ADR_DIR, 8'h00);
    // duty beyond the period keeps the pin high
    wr(`ADR_DUTY_LO, 8'hFF);
    meas(32, cnt);
    meas(16, cnt);
    chk_cnt("over period", 16, cnt);
    rd(`ADR_PIN_DATA, rv);
    chk_reg("pin readback", 8'h04, rv & 8'h04);
    $display("test pwm pin done");
    // off mode: port latch drives; output latch must drop
    wr(`ADR_UCTL, 8'h00);
    meas(8, cnt);
    chk_cnt("plain port pin", 8, cnt);
    wr(`ADR_UCTL, 8'h08);
    meas(4, cnt);
    chk_cnt("cleared latch", 0, cnt);
    pulse();
    meas(4, cnt);
    chk_cnt("compare set", 4, cnt);
    wr(`ADR_UCTL, 8'h09);
    pulse();
    meas(4, cnt);
    chk_cnt("compare clear", 0, cnt);
    // capture on a rising edge made by the pin data bit
    wr(`ADR_PIN_DATA, 8'h00);
    wr(`ADR_UCTL, 8'h05);
    idle(6);
    wr(`ADR_FLAGS, 8'h00);
    wr(`ADR_PIN_DATA, 8'h04);
    idle(6);
    rd(`ADR_FLAGS, rv);
    chk_reg("capture flag", 8'h04, rv & 8'h04);
    chk_reg("data bit pin", 8'h01, {7'h0, level});
    // capture on a falling edge when the data bit drops
    wr(`ADR_UCTL, 8'h04);
    idle(6);
    wr(`ADR_FLAGS, 8'h00);
    wr(`ADR_PIN_DATA, 8'h00);
    idle(6);
    rd(`ADR_FLAGS, rv);
    chk_reg("falling capture", 8'h04, rv & 8'h04);
    // postscaler still raises its own flag every 16 periods
    wr(`ADR_FLAGS, 8'h00);
    idle(600);
    rd(`ADR_FLAGS, rv);
    chk_reg("postscale flag", 8'h02, rv & 8'h02);
    $display("test modes done");
    complete_run();
  end
endmodule
